/* File: common/ccr_defs.svh */
// Register indices, field positions, masks and reset values of the calibration bank.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define CCR_IDX_CH1_OFS_HI 6'h0f
`define CCR_IDX_CH1_OFS_LO 6'h10
`define CCR_IDX_CH1_GAIN_HI 6'h11
`define CCR_IDX_CH1_GAIN_LO 6'h12
`define CCR_IDX_CH2_CONFIG 6'h13
`define CCR_IDX_CH2_OFS_HI 6'h14
`define CCR_IDX_CH2_OFS_LO 6'h15
`define CCR_IDX_CTRL 6'h1e
`define CCR_IDX_STATUS 6'h1f

// Reset values of the stored words.
`define CCR_OFS_HI_RST 16'h0000
`define CCR_OFS_LO_RST 16'h0000
`define CCR_GAIN_HI_RST 16'h8000
`define CCR_GAIN_LO_RST 16'h0000
`define CCR_CFG_RST 16'h0000
`define CCR_CTRL_RST 1'h0

// Writable bit masks; zero bits are read-only and always read zero.
`define CCR_MASK_HI 16'hffff
`define CCR_MASK_LO 16'hff00
`define CCR_MASK_CFG 16'hffc7

// Field positions.
`define CCR_LO_BYTE_MSB 15
`define CCR_LO_BYTE_LSB 8
`define CCR_INSEL_MSB 1
`define CCR_INSEL_LSB 0
`define CCR_CTRL_DIRECT_BIT 0
`define CCR_CTRL_COMMIT_BIT 1
`define CCR_STAT_DIRECT_BIT 0
`define CCR_STAT_PEND_LSB 1
`define CCR_STAT_PEND_MSB 3

// Pending and commit slot numbers.
`define CCR_SLOT_CH1_OFS 0
`define CCR_SLOT_CH1_GAIN 1
`define CCR_SLOT_CH2_OFS 2

`endif

/* File: common/ccr_pkg.sv */
// Types shared by the calibration register bank and its bus.
package ccr_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ccr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ccr_apb_rsp_t;

    typedef enum logic [1:0] {
        CCR_INSEL_NORMAL = 2'h0,
        CCR_INSEL_SHORTED = 2'h1,
        CCR_INSEL_TEST_POS = 2'h2,
        CCR_INSEL_TEST_NEG = 2'h3
    } ccr_insel_t;

    typedef struct packed {
        logic signed [23:0] offset;
        logic [23:0] gain;
    } ccr_chan_cal_t;

endpackage

/* File: rtl/ccr_cal_word.sv */
// One 16-bit stored register word with per-bit write mask and byte strobes.
`timescale 1ns/1ns
`include "ccr_defs.svh"

module ccr_cal_word #(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK = 16'hffff
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [1:0] wr_strb,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);

    logic [15:0] word_ff;
    logic [15:0] nxt_word;
    logic [15:0] lane_mask;

    // Masked bits keep their reset value, so read-only bits stay zero.
    always_comb begin
        lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & WR_MASK;
        nxt_word = word_ff;
        if (wr_en) begin
            nxt_word = (word_ff & ~lane_mask) | (wr_data & lane_mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_ff <= RST_VAL;
        end else begin
            word_ff <= nxt_word;
        end
    end

    assign value = word_ff;

endmodule

/* File: rtl/ccr_channel_cal_regs.sv */
// Channel 1 and channel 2 calibration and configuration registers behind an APB slave.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "ccr_defs.svh"

// How it works
// - offset high word holds value bits 23:8
// - offset low word bits 15:8 hold bits 7:0
// - low calibration words bits 7:0 read zero
// - gain is unsigned 24-bit, two words
// - gain resets to 8000h high, zero low
// - offsets and configuration reset to zero
// - input select codes normal, shorted, test
// - configuration bits 5:3 always read zero
module ccr_channel_cal_regs (
    input wire logic pclk,
    input wire logic presetn,
    input ccr_pkg::ccr_apb_req_t apb_req,
    output ccr_pkg::ccr_apb_rsp_t apb_rsp,
    output ccr_pkg::ccr_chan_cal_t ch1_cal,
    output logic signed [23:0] ch2_offset,
    output ccr_pkg::ccr_insel_t ch2_input_select,
    output logic ch2_inputs_connected,
    output logic ch2_inputs_shorted,
    output logic ch2_test_enable,
    output logic ch2_test_negative
);

    import ccr_pkg::*;

    logic setup_phase;
    logic wr_fire;
    logic [5:0] idx;
    logic aligned;
    logic mapped;
    logic writable;
    logic [1:0] wr_strb;
    logic [15:0] wr_data;

    logic wr_ch1_ofs_hi;
    logic wr_ch1_ofs_lo;
    logic wr_ch1_gain_hi;
    logic wr_ch1_gain_lo;
    logic wr_ch2_config;
    logic wr_ch2_ofs_hi;
    logic wr_ch2_ofs_lo;
    logic wr_ctrl;

    logic [15:0] ch1_ofs_hi;
    logic [15:0] ch1_ofs_lo;
    logic [15:0] ch1_gain_hi;
    logic [15:0] ch1_gain_lo;
    logic [15:0] ch2_config;
    logic [15:0] ch2_ofs_hi;
    logic [15:0] ch2_ofs_lo;

    logic direct_ff;
    logic nxt_direct;
    logic [2:0] pend_ff;
    logic [2:0] nxt_pend;
    logic [2:0] commit_ff;
    logic [2:0] nxt_commit;
    logic [23:0] ch1_ofs_app_ff;
    logic [23:0] nxt_ch1_ofs_app;
    logic [23:0] ch1_gain_app_ff;
    logic [23:0] nxt_ch1_gain_app;
    logic [23:0] ch2_ofs_app_ff;
    logic [23:0] nxt_ch2_ofs_app;

    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [15:0] rd_word;

    // Bus decode. Only word-aligned addresses of the listed indices are mapped.
    always_comb begin
        setup_phase = apb_req.psel & ~apb_req.penable;
        idx = apb_req.paddr[7:2];
        aligned = (apb_req.paddr[1:0] == 2'h0);
        wr_strb = apb_req.pstrb[1:0];
        wr_data = apb_req.pwdata[15:0];
        case (idx)
            `CCR_IDX_CH1_OFS_HI,
            `CCR_IDX_CH1_OFS_LO,
            `CCR_IDX_CH1_GAIN_HI,
            `CCR_IDX_CH1_GAIN_LO,
            `CCR_IDX_CH2_CONFIG,
            `CCR_IDX_CH2_OFS_HI,
            `CCR_IDX_CH2_OFS_LO,
            `CCR_IDX_CTRL: begin
                mapped = aligned;
                writable = aligned;
            end
            `CCR_IDX_STATUS: begin
                mapped = aligned;
                writable = 1'b0;
            end
            default: begin
                mapped = 1'b0;
                writable = 1'b0;
            end
        endcase
        wr_fire = apb_req.psel & apb_req.penable & apb_req.pwrite & writable;
    end

    always_comb begin
        wr_ch1_ofs_hi = wr_fire & (idx == `CCR_IDX_CH1_OFS_HI);
        wr_ch1_ofs_lo = wr_fire & (idx == `CCR_IDX_CH1_OFS_LO);
        wr_ch1_gain_hi = wr_fire & (idx == `CCR_IDX_CH1_GAIN_HI);
        wr_ch1_gain_lo = wr_fire & (idx == `CCR_IDX_CH1_GAIN_LO);
        wr_ch2_config = wr_fire & (idx == `CCR_IDX_CH2_CONFIG);
        wr_ch2_ofs_hi = wr_fire & (idx == `CCR_IDX_CH2_OFS_HI);
        wr_ch2_ofs_lo = wr_fire & (idx == `CCR_IDX_CH2_OFS_LO);
        wr_ctrl = wr_fire & (idx == `CCR_IDX_CTRL);
    end

    // Offset high words: all sixteen bits writable, reset to zero.
    ccr_cal_word #(
        .RST_VAL(`CCR_OFS_HI_RST),
        .WR_MASK(`CCR_MASK_HI)
    ) u_ch1_ofs_hi (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch1_ofs_hi),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch1_ofs_hi)
    );

    ccr_cal_word #(
        .RST_VAL(`CCR_OFS_HI_RST),
        .WR_MASK(`CCR_MASK_HI)
    ) u_ch2_ofs_hi (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch2_ofs_hi),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch2_ofs_hi)
    );

    // Lower words: only the upper byte stores, the lower byte reads zero; the gain high word stores all sixteen bits.
    ccr_cal_word #(
        .RST_VAL(`CCR_OFS_LO_RST),
        .WR_MASK(`CCR_MASK_LO)
    ) u_ch1_ofs_lo (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch1_ofs_lo),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch1_ofs_lo)
    );

    ccr_cal_word #(
        .RST_VAL(`CCR_OFS_LO_RST),
        .WR_MASK(`CCR_MASK_LO)
    ) u_ch2_ofs_lo (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch2_ofs_lo),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch2_ofs_lo)
    );

    ccr_cal_word #(
        .RST_VAL(`CCR_GAIN_HI_RST),
        .WR_MASK(`CCR_MASK_HI)
    ) u_ch1_gain_hi (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch1_gain_hi),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch1_gain_hi)
    );

    ccr_cal_word #(
        .RST_VAL(`CCR_GAIN_LO_RST),
        .WR_MASK(`CCR_MASK_LO)
    ) u_ch1_gain_lo (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch1_gain_lo),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch1_gain_lo)
    );

    // Reserved bits 15:6 and 2 are stored as written; bits 5:3 stay zero.
    ccr_cal_word #(
        .RST_VAL(`CCR_CFG_RST),
        .WR_MASK(`CCR_MASK_CFG)
    ) u_ch2_config (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch2_config),
        .wr_strb(wr_strb),
        .wr_data(wr_data),
        .value(ch2_config)
    );

    // Staged update: a high-word write waits for its low word, so in normal mode a
    // high-then-low pair reaches the applied 24-bit value in one step. Direct mode or a
    // commit request applies at once. Applied values change two cycles after the write.
    always_comb begin
        nxt_direct = direct_ff;
        nxt_pend = pend_ff;
        nxt_commit = 3'h0;
        if (wr_ctrl && wr_strb[0]) begin
            nxt_direct = wr_data[`CCR_CTRL_DIRECT_BIT];
            if (wr_data[`CCR_CTRL_COMMIT_BIT]) begin
                nxt_commit = 3'h7;
            end
        end
        if (wr_ch1_ofs_lo || (wr_ch1_ofs_hi && direct_ff)) begin
            nxt_commit[`CCR_SLOT_CH1_OFS] = 1'b1;
        end
        if (wr_ch1_gain_lo || (wr_ch1_gain_hi && direct_ff)) begin
            nxt_commit[`CCR_SLOT_CH1_GAIN] = 1'b1;
        end
        if (wr_ch2_ofs_lo || (wr_ch2_ofs_hi && direct_ff)) begin
            nxt_commit[`CCR_SLOT_CH2_OFS] = 1'b1;
        end
        nxt_pend = pend_ff & ~commit_ff;
        if (wr_ch1_ofs_hi && !direct_ff) begin
            nxt_pend[`CCR_SLOT_CH1_OFS] = 1'b1;
        end
        if (wr_ch1_gain_hi && !direct_ff) begin
            nxt_pend[`CCR_SLOT_CH1_GAIN] = 1'b1;
        end
        if (wr_ch2_ofs_hi && !direct_ff) begin
            nxt_pend[`CCR_SLOT_CH2_OFS] = 1'b1;
        end
    end

    always_comb begin
        nxt_ch1_ofs_app = ch1_ofs_app_ff;
        nxt_ch1_gain_app = ch1_gain_app_ff;
        nxt_ch2_ofs_app = ch2_ofs_app_ff;
        if (commit_ff[`CCR_SLOT_CH1_OFS]) begin
            nxt_ch1_ofs_app = {ch1_ofs_hi, ch1_ofs_lo[15:8]};
        end
        if (commit_ff[`CCR_SLOT_CH1_GAIN]) begin
            nxt_ch1_gain_app = {ch1_gain_hi, ch1_gain_lo[15:8]};
        end
        if (commit_ff[`CCR_SLOT_CH2_OFS]) begin
            nxt_ch2_ofs_app = {ch2_ofs_hi, ch2_ofs_lo[15:8]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direct_ff <= `CCR_CTRL_RST;
            pend_ff <= 3'h0;
            commit_ff <= 3'h0;
            ch1_ofs_app_ff <= {`CCR_OFS_HI_RST, 8'(`CCR_OFS_LO_RST >> 8)};
            ch1_gain_app_ff <= {`CCR_GAIN_HI_RST, 8'(`CCR_GAIN_LO_RST >> 8)};
            ch2_ofs_app_ff <= {`CCR_OFS_HI_RST, 8'(`CCR_OFS_LO_RST >> 8)};
        end else begin
            direct_ff <= nxt_direct;
            pend_ff <= nxt_pend;
            commit_ff <= nxt_commit;
            ch1_ofs_app_ff <= nxt_ch1_ofs_app;
            ch1_gain_app_ff <= nxt_ch1_gain_app;
            ch2_ofs_app_ff <= nxt_ch2_ofs_app;
        end
    end

    // Read data is captured in the setup phase and held through the access.
    always_comb begin
        rd_word = 16'h0000;
        case (idx)
            `CCR_IDX_CH1_OFS_HI: rd_word = ch1_ofs_hi;
            `CCR_IDX_CH1_OFS_LO: rd_word = ch1_ofs_lo;
            `CCR_IDX_CH1_GAIN_HI: rd_word = ch1_gain_hi;
            `CCR_IDX_CH1_GAIN_LO: rd_word = ch1_gain_lo;
            `CCR_IDX_CH2_CONFIG: rd_word = ch2_config;
            `CCR_IDX_CH2_OFS_HI: rd_word = ch2_ofs_hi;
            `CCR_IDX_CH2_OFS_LO: rd_word = ch2_ofs_lo;
            `CCR_IDX_CTRL: rd_word = {15'h0000, direct_ff};
            `CCR_IDX_STATUS: rd_word = {12'h000, pend_ff, direct_ff};
            default: rd_word = 16'h0000;
        endcase
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup_phase) begin
            nxt_pslverr = apb_req.pwrite ? ~writable : ~mapped;
            nxt_prdata = 32'h0000_0000;
            if (!apb_req.pwrite && mapped) begin
                nxt_prdata = {16'h0000, rd_word};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_comb begin
        apb_rsp.prdata = prdata_ff;
        apb_rsp.pready = apb_req.psel & apb_req.penable;
        apb_rsp.pslverr = pslverr_ff & apb_req.psel & apb_req.penable;
    end

    // Applied calibration values and decoded input selection.
    always_comb begin
        ch1_cal.offset = ch1_ofs_app_ff;
        ch1_cal.gain = ch1_gain_app_ff;
        ch2_offset = ch2_ofs_app_ff;
        ch2_input_select = ccr_insel_t'(ch2_config[`CCR_INSEL_MSB:`CCR_INSEL_LSB]);
        ch2_inputs_connected = (ch2_input_select == CCR_INSEL_NORMAL);
        ch2_inputs_shorted = (ch2_input_select == CCR_INSEL_SHORTED);
        ch2_test_enable = ch2_input_select[1];
        ch2_test_negative = (ch2_input_select == CCR_INSEL_TEST_NEG);
    end

endmodule

/* File: tb/ccr_channel_cal_regs_asserts.sv */
// Checker for the calibration register bank ports, bound to the design top.
`timescale 1ns/1ns
`include "ccr_defs.svh"

module ccr_channel_cal_regs_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire ccr_pkg::ccr_apb_req_t apb_req,
    input wire ccr_pkg::ccr_apb_rsp_t apb_rsp,
    input wire ccr_pkg::ccr_chan_cal_t ch1_cal,
    input wire logic signed [23:0] ch2_offset,
    input wire ccr_pkg::ccr_insel_t ch2_input_select,
    input wire logic ch2_inputs_connected,
    input wire logic ch2_inputs_shorted,
    input wire logic ch2_test_enable,
    input wire logic ch2_test_negative
);
    import ccr_pkg::*;
    logic acc;
    logic rd_acc;
    logic [5:0] idx;
    logic wr_ofs;
    logic wr_gain;
    assign acc = apb_req.psel & apb_req.penable;
    assign rd_acc = acc & ~apb_req.pwrite;
    assign idx = apb_req.paddr[7:2];
    assign wr_ofs = acc & apb_req.pwrite & (idx inside {`CCR_IDX_CH1_OFS_HI,
        `CCR_IDX_CH1_OFS_LO, `CCR_IDX_CTRL});
    assign wr_gain = acc & apb_req.pwrite & (idx inside {`CCR_IDX_CH1_GAIN_HI,
        `CCR_IDX_CH1_GAIN_LO, `CCR_IDX_CTRL});
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_read_lo_zero: assert property (rd_acc && (idx inside {`CCR_IDX_CH1_OFS_LO,
        `CCR_IDX_CH1_GAIN_LO, `CCR_IDX_CH2_OFS_LO}) |-> apb_rsp.prdata[7:0] == 8'h00)
        else $error("reserved low byte read nonzero");
    a_read_cfg_zero: assert property (rd_acc && idx == `CCR_IDX_CH2_CONFIG
        |-> apb_rsp.prdata[5:3] == 3'h0) else $error("config bits 5:3 read nonzero");
    a_gain_reset: assert property ($rose(presetn) |-> ch1_cal.gain == 24'h800000)
        else $error("gain not unity after reset");
    a_zero_reset: assert property ($rose(presetn) |-> ch1_cal.offset == 24'h000000
        && ch2_offset == 24'h000000 && ch2_input_select == CCR_INSEL_NORMAL)
        else $error("offset or select not zero after reset");
    a_sel_connected: assert property (ch2_inputs_connected == (ch2_input_select == 2'h0))
        else $error("connected flag wrong");
    a_sel_shorted: assert property (ch2_inputs_shorted == (ch2_input_select == 2'h1))
        else $error("shorted flag wrong");
    a_sel_test: assert property (ch2_test_enable == ch2_input_select[1]
        && ch2_test_negative == (ch2_input_select == 2'h3)) else $error("test flags wrong");
    a_ofs_cause: assert property ($changed(ch1_cal.offset) |-> $past(wr_ofs, 2))
        else $error("ch1 offset changed without write");
    a_gain_cause: assert property ($changed(ch1_cal.gain) |-> $past(wr_gain, 2))
        else $error("ch1 gain changed without write");

    c_cfg_write: cover property (acc && apb_req.pwrite && idx == `CCR_IDX_CH2_CONFIG);
    c_ofs_change: cover property ($changed(ch1_cal.offset));
    c_test_neg: cover property (ch2_test_negative);
endmodule

bind ccr_channel_cal_regs ccr_channel_cal_regs_asserts i_ccr_channel_cal_regs_asserts (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ch1_cal(ch1_cal), .ch2_offset(ch2_offset), .ch2_input_select(ch2_input_select),
    .ch2_inputs_connected(ch2_inputs_connected), .ch2_inputs_shorted(ch2_inputs_shorted),
    .ch2_test_enable(ch2_test_enable), .ch2_test_negative(ch2_test_negative));

/* File: tb/ccr_host_model.sv */
// Host controller model that issues APB transfers to the register bank.
`timescale 1ns/1ns
`include "ccr_defs.svh"

module ccr_host_model (
    input wire logic pclk,
    output ccr_pkg::ccr_apb_req_t apb_req,
    input wire ccr_pkg::ccr_apb_rsp_t apb_rsp
);
    import ccr_pkg::*;
    initial begin
        apb_req = '0;
    end
    // Released lines show the inverse pattern so stale values never look valid.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic er);
        logic [15:0] dv;
        dv = d;
        if (w && a[7:2] == `CCR_IDX_CH2_CONFIG) begin
            dv = d & 16'h003b;
        end
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
            pwdata: {16'h0000, dv}, pstrb: s};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a,
            pwdata: ~{16'h0000, dv}, pstrb: ~s};
    endtask
endmodule

/* File: tb/channel_cal_config_regs_bench.sv */
// Self-checking bench for the calibration register bank with a register model.
`timescale 1ns/1ns

module channel_cal_config_regs_bench;
    import ccr_pkg::*;
    logic pclk;
    logic presetn;
    ccr_apb_req_t apb_req;
    ccr_apb_rsp_t apb_rsp;
    ccr_chan_cal_t ch1_cal;
    logic signed [23:0] ch2_offset;
    ccr_insel_t ch2_input_select;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 23;
    logic [15:0] mreg [15:21];
    logic [31:0] rd;
    logic er;
    logic ch2_inputs_connected;
    logic ch2_inputs_shorted;
    logic ch2_test_enable;
    logic ch2_test_negative;
    logic [23:0] gsave;

    ccr_channel_cal_regs i_ccr_channel_cal_regs (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .ch1_cal(ch1_cal), .ch2_offset(ch2_offset),
        .ch2_input_select(ch2_input_select), .ch2_inputs_connected(ch2_inputs_connected),
        .ch2_inputs_shorted(ch2_inputs_shorted), .ch2_test_enable(ch2_test_enable),
        .ch2_test_negative(ch2_test_negative));
    ccr_host_model i_ccr_host_model (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function automatic logic [15:0] wmask(input int i);
        case (i)
            16, 18, 21: return 16'hff00;
            19: return 16'hffc7;
            default: return 16'hffff;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic m_reset;
        for (int i = 15; i <= 21; i++) mreg[i] = 16'h0000;
        mreg[17] = 16'h8000;
    endtask

    task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] wm;
        wm = wmask(i) & {{8{s[1]}}, {8{s[0]}}};
        if (i == 19) d = d & 16'h003b;
        i_ccr_host_model.xfer(1'b1, 8'(i * 4), d, s, rd, er);
        mreg[i] = (mreg[i] & ~wm) | (d & wm);
        chk("write error", 32'h0, {31'h0, er});
    endtask

    task automatic rdchk(input int i);
        i_ccr_host_model.xfer(1'b0, 8'(i * 4), 16'h0000, 4'h0, rd, er);
        chk("read data", {16'h0000, mreg[i]}, rd);
        chk("read error", 32'h0, {31'h0, er});
    endtask

    task automatic errchk(input logic w, input logic [7:0] a);
        i_ccr_host_model.xfer(w, a, 16'hffff, 4'hf, rd, er);
        chk("error flag", 32'h1, {31'h0, er});
        if (!w) chk("error data", 32'h0, rd);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end

    initial begin
        int idx;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m_reset();
        for (int i = 15; i <= 21; i++) rdchk(i);
        chk("reset gain", 32'h800000, {8'h00, ch1_cal.gain});
        for (int n = 0; n < 30; n++) begin
            idx = 15 + {$random(seed)} % 7;
            wr(idx, 16'($random(seed)), 4'($random(seed)));
            rdchk(idx);
        end
        for (int i = 15; i <= 21; i++) if (i != 19) wr(i, 16'($random(seed)), 4'h3);
        repeat (3) @(posedge pclk);
        chk("ch1 offset", {8'h00, mreg[15], mreg[16][15:8]}, {8'h00, ch1_cal.offset});
        chk("ch1 gain", {8'h00, mreg[17], mreg[18][15:8]}, {8'h00, ch1_cal.gain});
        chk("ch2 offset", {8'h00, mreg[20], mreg[21][15:8]}, {8'h00, ch2_offset});
        // Direct mode applies a lone high word; normal mode stages it until commit-all.
        i_ccr_host_model.xfer(1'b1, 8'h78, 16'h0001, 4'h1, rd, er);
        i_ccr_host_model.xfer(1'b0, 8'h7c, 16'h0000, 4'h0, rd, er);
        chk("status direct", 32'h1, rd);
        wr(15, 16'($random(seed)), 4'h3);
        repeat (3) @(posedge pclk);
        chk("direct offset", {8'h00, mreg[15], mreg[16][15:8]}, {8'h00, ch1_cal.offset});
        i_ccr_host_model.xfer(1'b1, 8'h78, 16'h0000, 4'h1, rd, er);
        gsave = {mreg[17], mreg[18][15:8]};
        wr(17, 16'($random(seed)), 4'h3);
        i_ccr_host_model.xfer(1'b0, 8'h7c, 16'h0000, 4'h0, rd, er);
        chk("status pending", 32'h4, rd);
        chk("staged gain", {8'h00, gsave}, {8'h00, ch1_cal.gain});
        i_ccr_host_model.xfer(1'b1, 8'h78, 16'h0002, 4'h1, rd, er);
        repeat (3) @(posedge pclk);
        chk("commit gain", {8'h00, mreg[17], mreg[18][15:8]}, {8'h00, ch1_cal.gain});
        i_ccr_host_model.xfer(1'b0, 8'h7c, 16'h0000, 4'h0, rd, er);
        chk("status clear", 32'h0, rd);
        for (int c = 0; c < 4; c++) begin
            wr(19, 16'(c), 4'h3);
            rdchk(19);
            chk("input select", 32'(c), {30'h0, ch2_input_select});
            chk("connected", 32'(c == 0), {31'h0, ch2_inputs_connected});
            chk("shorted", 32'(c == 1), {31'h0, ch2_inputs_shorted});
            chk("test enable", 32'(c >= 2), {31'h0, ch2_test_enable});
            chk("test negative", 32'(c == 3), {31'h0, ch2_test_negative});
        end
        errchk(1'b0, 8'h80);
        errchk(1'b1, 8'h7c);
        errchk(1'b1, 8'h41);
        rdchk(16);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m_reset();
        rdchk(17);
        rdchk(16);
        final_report();
    end
endmodule
